//--- hdl/mxd_motion_xdelta.v
// motion status byte and x displacement low byte of the navigation sensor
// assumes: the serial port front end turns each register access into a
// one-cycle read or write strobe with address, all synchronous to sys_clk_in;
// the tracker delivers one signed delta pair per valid cycle;
// the y low and shared high bytes are served here too, so neighbouring
// blocks only see the snapshot through the y_low and high outputs
`include "mxd_consts.vh"

// Overview of operation
// - status bit 7 flags displacement accumulated since the last report
// - any status write clears pending, overflow and all displacement; data dropped
// - overflow of either 12-bit accumulator sets status bit 4
// - while overflow is set, accumulators stop adding and hold their values
// - once the status byte is read, accumulators and overflow are cleared
// - bit 4 reads 1 only if an overflow happened since the last report
// - bit 3 reads 1 while laser power settings are valid
// - bit 2 reads 1 while the emitter cathode short detector trips
// - bit 0 reads 1 once a power-up reset has been triggered
// - register 0x03 holds the low eight bits of x displacement since report
// - reading the x low byte clears it after its value is returned
// - x displacement is 12-bit two's complement, -2048 to +2047
module mxd_motion_xdelta (
  // clock, reset, enable
  input  wire                   sys_clk_in,
  input  wire                   rst_in,
  input  wire                   ce_in,
  // register access from the serial port front end
  input  wire [`MXD_ADDR_W-1:0] reg_addr_in,
  input  wire                   reg_rd_in,
  input  wire                   reg_wr_in,
  input  wire [`MXD_DATA_W-1:0] reg_wdata_in,
  output reg  [`MXD_DATA_W-1:0] reg_rdata_out,
  output reg                    reg_rdata_valid_out,
  // displacement from the tracker
  input  wire                   delta_valid_in,
  input  wire [`MXD_DATA_W-1:0] x_delta_in,
  input  wire [`MXD_DATA_W-1:0] y_delta_in,
  // analogue monitors and reset source
  input  wire                   laser_power_ok_in,
  input  wire                   emitter_short_fault_in,
  input  wire                   power_up_reset_in,
  // status and snapshot towards neighbours and the motion pin
  output wire                   motion_pending_out,
  output wire                   accum_overflow_out,
  output reg  [`MXD_DATA_W-1:0] y_low_out,
  output reg  [`MXD_DATA_W-1:0] xy_motion_high_out
);

  // address match, shared by the read and write decoders
  function addr_is;
    input [`MXD_ADDR_W-1:0] addr;
    input [`MXD_ADDR_W-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // reset value of each status bit, cut from the status reset byte so the
  // flag instances and the monitor registers always agree with it
  localparam [`MXD_DATA_W-1:0] STATUS_RST   = `MXD_STATUS_RESET;
  localparam [0:0]             RST_MOTION   = STATUS_RST[`MXD_BIT_MOTION];
  localparam [0:0]             RST_OVF      = STATUS_RST[`MXD_BIT_OVF];
  localparam [0:0]             RST_LASER_OK = STATUS_RST[`MXD_BIT_LASER_OK];
  localparam [0:0]             RST_FAULT    = STATUS_RST[`MXD_BIT_FAULT];
  localparam [0:0]             RST_FLAG     = STATUS_RST[`MXD_BIT_RST_FLAG];

  // access strobes
  wire acc_wr;
  wire acc_rd;
  wire wr_status;
  wire rd_status;
  wire rd_x_low;
  wire rd_y_low;
  wire rd_xy_high;

  // a write and a read in one cycle: the write is taken, the read dropped,
  // since the write clears everything that the read would have reported
  assign acc_wr     = reg_wr_in;
  assign acc_rd     = reg_rd_in & ~reg_wr_in;
  assign wr_status  = acc_wr & addr_is(reg_addr_in, `MXD_REG_STATUS);
  assign rd_status  = acc_rd & addr_is(reg_addr_in, `MXD_REG_STATUS);
  assign rd_x_low   = acc_rd & addr_is(reg_addr_in, `MXD_REG_X_LOW);
  assign rd_y_low   = acc_rd & addr_is(reg_addr_in, `MXD_REG_Y_LOW);
  assign rd_xy_high = acc_rd & addr_is(reg_addr_in, `MXD_REG_XY_HIGH);

  // flag and accumulator state
  wire                               motion_pending;
  wire                               accum_overflow;
  wire                               laser_power_ok;
  wire                               emitter_short_fault;
  wire                               rst_flag;
  wire [`MXD_AXIS_N*`MXD_ACC_W-1:0]  acc_flat;
  wire [`MXD_AXIS_N*`MXD_DATA_W-1:0] delta_flat;
  wire [`MXD_AXIS_N-1:0]             axis_ovf;
  wire [`MXD_ACC_W-1:0]              x_acc;
  wire [`MXD_ACC_W-1:0]              y_acc;
  wire                               add_en;
  wire                               any_ovf;
  wire                               acc_clear;
  wire                               delta_nonzero;
  wire                               motion_set;
  wire                               overflow_set;

  // snapshot and read side state
  reg  [`MXD_DATA_W-1:0]             x_low;
  reg  [`MXD_DATA_W-1:0]             status_byte;

  // no new counts enter while an overflow is being reported
  assign add_en        = delta_valid_in & ~accum_overflow;
  assign any_ovf       = |axis_ovf;
  assign delta_nonzero = (x_delta_in != `MXD_BYTE_ZERO) | (y_delta_in != `MXD_BYTE_ZERO);

  // an overflowing sample still marks motion: nothing is added, but the
  // controller must come and collect the overflow report all the same
  assign motion_set    = add_en & delta_nonzero;
  assign overflow_set  = any_ovf;

  // a status read hands the count to the snapshot, a status write drops it;
  // either way counting restarts from zero at that very edge
  assign acc_clear  = rd_status | wr_status;
  assign delta_flat = {y_delta_in, x_delta_in};
  assign x_acc      = acc_flat[`MXD_AXIS_X*`MXD_ACC_W +: `MXD_ACC_W];
  assign y_acc      = acc_flat[`MXD_AXIS_Y*`MXD_ACC_W +: `MXD_ACC_W];

  // one accumulator per axis; either overflowing freezes both, so the two
  // axes never disagree about which samples made it into the report
  genvar g;
  generate
    for (g = 0; g < `MXD_AXIS_N; g = g + 1) begin : g_axis
      mxd_axis_accum u_accum (
        .clk_in    (sys_clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .clr_in    (acc_clear),
        .add_in    (add_en),
        .freeze_in (any_ovf),
        .delta_in  (delta_flat[g*`MXD_DATA_W +: `MXD_DATA_W]),
        .acc_out   (acc_flat[g*`MXD_ACC_W +: `MXD_ACC_W]),
        .ovf_out   (axis_ovf[g])
      );
    end
  endgenerate

  // pending motion: set by any nonzero delta taken in, cleared on report
  mxd_sticky_flag #(
    .RESET_VAL (RST_MOTION)
  ) u_motion (
    .clk_in   (sys_clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .set_in   (motion_set),
    .clr_in   (acc_clear),
    .flag_out (motion_pending)
  );

  // overflow since last report; the clearing read still returns the 1
  mxd_sticky_flag #(
    .RESET_VAL (RST_OVF)
  ) u_overflow (
    .clk_in   (sys_clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .set_in   (overflow_set),
    .clr_in   (acc_clear),
    .flag_out (accum_overflow)
  );

  // reset indicator: reset itself and any later power-up event set it;
  // nothing in this block clears it, software sees it stay at 1;
  // a clearing path, if ever wanted, belongs to the power management side
  mxd_sticky_flag #(
    .RESET_VAL (RST_FLAG)
  ) u_rst_flag (
    .clk_in   (sys_clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .set_in   (power_up_reset_in),
    .clr_in   (`MXD_BIT_CLEAR),
    .flag_out (rst_flag)
  );

  // monitor levels are registered so a read sees one stable value; the
  // price is one cycle of lag on both monitor bits
  reg laser_ok_q;
  reg fault_q;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      laser_ok_q <= RST_LASER_OK;
      fault_q    <= RST_FAULT;
    end else if (ce_in) begin
      laser_ok_q <= laser_power_ok_in;
      fault_q    <= emitter_short_fault_in;
    end
  end

  assign laser_power_ok      = laser_ok_q;
  assign emitter_short_fault = fault_q;

  // status byte as read; reserved bits read as zero
  // assembled every cycle, only the read path registers it
  always @* begin
    status_byte                    = `MXD_BYTE_ZERO;
    status_byte[`MXD_BIT_RSV6]     = `MXD_BIT_CLEAR;
    status_byte[`MXD_BIT_RSV5]     = `MXD_BIT_CLEAR;
    status_byte[`MXD_BIT_RSV1]     = `MXD_BIT_CLEAR;
    status_byte[`MXD_BIT_MOTION]   = motion_pending;
    status_byte[`MXD_BIT_OVF]      = accum_overflow;
    status_byte[`MXD_BIT_LASER_OK] = laser_power_ok;
    status_byte[`MXD_BIT_FAULT]    = emitter_short_fault;
    status_byte[`MXD_BIT_RST_FLAG] = rst_flag;
  end

  // snapshot next values: the status read loads all three together so that
  // the following reads of 0x03..0x05 belong to one sample, even while new
  // motion keeps counting in the accumulators behind them; a status write
  // empties them; otherwise each byte clears once it has been returned
  reg [`MXD_DATA_W-1:0] next_x_low;
  reg [`MXD_DATA_W-1:0] next_y_low;
  reg [`MXD_DATA_W-1:0] next_xy_high;

  always @* begin
    next_x_low   = x_low;
    next_y_low   = y_low_out;
    next_xy_high = xy_motion_high_out;
    if (wr_status) begin
      // written byte is ignored, only the clear takes effect
      next_x_low   = `MXD_BYTE_ZERO;
      next_y_low   = `MXD_BYTE_ZERO;
      next_xy_high = `MXD_BYTE_ZERO;
    end else if (rd_status) begin
      next_x_low   = x_acc[`MXD_DATA_W-1:0];
      next_y_low   = y_acc[`MXD_DATA_W-1:0];
      next_xy_high = {x_acc[`MXD_ACC_W-1:`MXD_DATA_W],
                      y_acc[`MXD_ACC_W-1:`MXD_DATA_W]};
    end else begin
      if (rd_x_low) begin
        next_x_low = `MXD_BYTE_ZERO;
      end
      if (rd_y_low) begin
        next_y_low = `MXD_BYTE_ZERO;
      end
      if (rd_xy_high) begin
        next_xy_high = `MXD_BYTE_ZERO;
      end
    end
  end

  // snapshot registers, frozen with the clock enable like everything else
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      x_low              <= `MXD_BYTE_ZERO;
      y_low_out          <= `MXD_BYTE_ZERO;
      xy_motion_high_out <= `MXD_BYTE_ZERO;
    end else if (ce_in) begin
      x_low              <= next_x_low;
      y_low_out          <= next_y_low;
      xy_motion_high_out <= next_xy_high;
    end
  end

  // read data selection by offset; offsets outside this block answer zero
  reg [`MXD_DATA_W-1:0] next_rdata;

  always @* begin
    case (reg_addr_in)
      `MXD_REG_STATUS:  next_rdata = status_byte;
      `MXD_REG_X_LOW:   next_rdata = x_low;
      `MXD_REG_Y_LOW:   next_rdata = y_low_out;
      `MXD_REG_XY_HIGH: next_rdata = xy_motion_high_out;
      default:          next_rdata = `MXD_BYTE_ZERO;
    endcase
  end

  // read data: answered one cycle after the strobe, from the old contents
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out       <= `MXD_BYTE_ZERO;
      reg_rdata_valid_out <= `MXD_BIT_CLEAR;
    end else if (ce_in) begin
      reg_rdata_valid_out <= acc_rd;
      if (acc_rd) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  // flag levels leave straight from their flip-flops inside the sticky
  // flag instances; no logic sits between them and the pins
  assign motion_pending_out = motion_pending;
  assign accum_overflow_out = accum_overflow;

endmodule

//--- hdl/mxd_consts.vh
// named constants of the motion status and x displacement read-out block
// assumes: included by bare name from every design file of the block
`ifndef MXD_CONSTS_VH
`define MXD_CONSTS_VH

// widths
`define MXD_ADDR_W        8
`define MXD_DATA_W        8
`define MXD_ACC_W         12
`define MXD_NIB_W         4
`define MXD_AXIS_N        2

// axis slots in the generate loop
`define MXD_AXIS_X        0
`define MXD_AXIS_Y        1

// register offsets
`define MXD_REG_STATUS    8'h02
`define MXD_REG_X_LOW     8'h03
`define MXD_REG_Y_LOW     8'h04
`define MXD_REG_XY_HIGH   8'h05

// status register layout and reset value
`define MXD_STATUS_RESET  8'h09
`define MXD_BIT_MOTION    7
`define MXD_BIT_RSV6      6
`define MXD_BIT_RSV5      5
`define MXD_BIT_OVF       4
`define MXD_BIT_LASER_OK  3
`define MXD_BIT_FAULT     2
`define MXD_BIT_RSV1      1
`define MXD_BIT_RST_FLAG  0

// fill values
`define MXD_BYTE_ZERO     8'h00
`define MXD_ACC_ZERO      12'h000
`define MXD_BIT_CLEAR     1'b0
`define MXD_BIT_SET       1'b1

`endif

//--- hdl/mxd_sticky_flag.v
// one sticky status flag: set by a hardware event, cleared by an access
// assumes: one synchronous clock, synchronous active high reset, clock enable
`include "mxd_consts.vh"

module mxd_sticky_flag #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  // clock and control
  input  wire clk_in,
  input  wire rst_in,
  input  wire ce_in,
  // event and clear
  input  wire set_in,
  input  wire clr_in,
  // flag
  output reg  flag_out
);

  // set beats clear so an event landing on the clearing access is kept
  always @(posedge clk_in) begin
    if (rst_in) begin
      flag_out <= RESET_VAL;
    end else if (ce_in) begin
      if (set_in) begin
        flag_out <= `MXD_BIT_SET;
      end else if (clr_in) begin
        flag_out <= `MXD_BIT_CLEAR;
      end
    end
  end

endmodule

//--- hdl/mxd_axis_accum.v
// one 12-bit two's complement displacement accumulator for a single axis
// assumes: deltas arrive as signed bytes, one per valid cycle, from the tracker
`include "mxd_consts.vh"

module mxd_axis_accum (
  // clock and control
  input  wire                    clk_in,
  input  wire                    rst_in,
  input  wire                    ce_in,
  // accumulate control
  input  wire                    clr_in,
  input  wire                    add_in,
  input  wire                    freeze_in,
  input  wire [`MXD_DATA_W-1:0]  delta_in,
  // state
  output reg  [`MXD_ACC_W-1:0]   acc_out,
  output wire                    ovf_out
);

  wire [`MXD_ACC_W-1:0] base;
  wire [`MXD_ACC_W:0]   sum;

  // a clear in the same cycle starts the new count from this delta
  assign base = clr_in ? `MXD_ACC_ZERO : acc_out;

  // one guard bit: sign of guard and msb differ when past -2048..+2047
  assign sum = {base[`MXD_ACC_W-1], base} +
               {{(`MXD_ACC_W+1-`MXD_DATA_W){delta_in[`MXD_DATA_W-1]}}, delta_in};
  assign ovf_out = add_in & (sum[`MXD_ACC_W] ^ sum[`MXD_ACC_W-1]);

  // hold the count on any overflow so the last valid path stays readable
  always @(posedge clk_in) begin
    if (rst_in) begin
      acc_out <= `MXD_ACC_ZERO;
    end else if (ce_in) begin
      if (add_in && !freeze_in) begin
        acc_out <= sum[`MXD_ACC_W-1:0];
      end else if (clr_in) begin
        acc_out <= `MXD_ACC_ZERO;
      end
    end
  end

endmodule

//--- bench/mxd_motion_xdelta_sva.sv
// port assertions of the motion status and x displacement block
// assumes: bound to mxd_motion_xdelta, one clock, synchronous reset
`include "mxd_consts.vh"
module mxd_chk (
  // clock and control
  input logic       sys_clk_in,
  input logic       rst_in,
  input logic       ce_in,
  // register port
  input logic [7:0] reg_addr_in,
  input logic       reg_rd_in,
  input logic       reg_wr_in,
  input logic [7:0] reg_rdata_out,
  input logic       reg_rdata_valid_out,
  // motion, monitors, flags
  input logic       delta_valid_in,
  input logic [7:0] x_delta_in,
  input logic [7:0] y_delta_in,
  input logic       laser_power_ok_in,
  input logic       emitter_short_fault_in,
  input logic       motion_pending_out,
  input logic       accum_overflow_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // accepted strobes; a write beats a read in the same cycle
  wire rd_ok = ce_in && reg_rd_in && !reg_wr_in;
  wire st_rd = rd_ok && reg_addr_in == `MXD_REG_STATUS;
  wire st_wr = ce_in && reg_wr_in && reg_addr_in == `MXD_REG_STATUS;
  wire clr   = st_rd || st_wr;
  wire mv    = ce_in && delta_valid_in && (x_delta_in != 8'h00 || y_delta_in != 8'h00);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  chk_read_answer: assert property (rd_ok |=> reg_rdata_valid_out)
    else $error("read got no answer");
  chk_answer_cause: assert property (reg_rdata_valid_out |-> $past(rd_ok))
    else $error("answer without read");
  chk_motion_set: assert property (mv && !accum_overflow_out |=> motion_pending_out)
    else $error("motion not flagged");
  chk_write_clears: assert property (st_wr && !delta_valid_in |=>
    !motion_pending_out && !accum_overflow_out)
    else $error("status write left flags");
  chk_read_clears: assert property (st_rd && !delta_valid_in |=>
    !motion_pending_out && !accum_overflow_out)
    else $error("status read left flags");
  chk_ovf_sticky: assert property (accum_overflow_out && !clr |=> accum_overflow_out)
    else $error("overflow dropped early");
  chk_ovf_cause: assert property ($rose(accum_overflow_out) |-> $past(delta_valid_in))
    else $error("overflow without motion");
  chk_status_flags: assert property (st_rd |=>
    reg_rdata_out[7] == $past(motion_pending_out) &&
    reg_rdata_out[4] == $past(accum_overflow_out))
    else $error("status flag bits wrong");
  chk_status_fixed: assert property (st_rd |=>
    reg_rdata_out[0] && reg_rdata_out[6:5] == 2'b00 && !reg_rdata_out[1])
    else $error("status fixed bits wrong");
  chk_monitor_bits: assert property (
    st_rd && $past(ce_in) && !$past(rst_in) |=>
    reg_rdata_out[3:2] == {$past(laser_power_ok_in, 2), $past(emitter_short_fault_in, 2)})
    else $error("monitor bits wrong");
  chk_rdata_hold: assert property (!reg_rdata_valid_out && !$past(rst_in) |->
    $stable(reg_rdata_out))
    else $error("read data moved");

  // main scenarios reached
  cov_status_read: cover property (st_rd);
  cov_status_write: cover property (st_wr);
  cov_overflow: cover property ($rose(accum_overflow_out));
  cov_x_read: cover property (rd_ok && reg_addr_in == `MXD_REG_X_LOW);
endmodule

bind mxd_motion_xdelta mxd_chk u_mxd_chk (.sys_clk_in, .rst_in, .ce_in, .reg_addr_in,
  .reg_rd_in, .reg_wr_in, .reg_rdata_out, .reg_rdata_valid_out, .delta_valid_in,
  .x_delta_in, .y_delta_in, .laser_power_ok_in, .emitter_short_fault_in,
  .motion_pending_out, .accum_overflow_out);

//--- bench/mxd_ctrl_model.sv
// controller model on the register side: read bursts and writes
// assumes: strobe taken at the next rising edge, answer one cycle later
module mxd_ctrl_model (
  // clock
  input  logic       clk_in,
  // register port
  output logic [7:0] addr_out,
  output logic       rd_out,
  output logic       wr_out,
  output logic [7:0] wdata_out,
  input  logic [7:0] rdata_in,
  input  logic       valid_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    addr_out = 8'hff;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  // back to back reads at ascending offsets; a released address shows its inverse
  task automatic burst(input logic [7:0] a0, input int n, output logic [7:0] d [4],
                       output int got);
    int k;
    got = 0;
    for (k = 0; k <= n; k++) begin
      @(posedge clk_in);
      rd_out <= (k < n);
      addr_out <= (k < n) ? a0 + 8'(k) : ~addr_out;
      #1;
      if (valid_in && got < 4) begin
        d[got] = rdata_in;
        got++;
      end
    end
  endtask
  // one write strobe, data released to its inverse
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= v;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~v;
  endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench of the motion status and x displacement block
// assumes: controller model drives the register port, bench drives motion
`include "mxd_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk_in, rst_in, ce_in, rd, wr, dv, lp, sf, pur, vld, mp, ov;
  logic [7:0] addr, wdata, xd, yd, rdata, yl, xyh;
  logic [7:0] d [4];
  int         n_errors, checks, got, xacc, yacc, r, i, k;
  bit         m_pend, m_ovf;

  mxd_motion_xdelta u_mxd_motion_xdelta (.sys_clk_in, .rst_in, .ce_in, .reg_addr_in(addr),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rdata_valid_out(vld), .delta_valid_in(dv), .x_delta_in(xd), .y_delta_in(yd),
    .laser_power_ok_in(lp), .emitter_short_fault_in(sf), .power_up_reset_in(pur),
    .motion_pending_out(mp), .accum_overflow_out(ov), .y_low_out(yl),
    .xy_motion_high_out(xyh));
  mxd_ctrl_model u_mxd_ctrl_model (.clk_in(sys_clk_in), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wdata_out(wdata), .rdata_in(rdata), .valid_in(vld));

  // 20 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // byte compare, counted
  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string what);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // expected status byte and shared high byte from the bench model
  function automatic logic [7:0] exp_status();
    return {m_pend, 2'b00, m_ovf, lp, sf, 1'b0, 1'b1};
  endfunction
  function automatic logic [7:0] exp_hi();
    return {xacc[11:8], yacc[11:8]};
  endfunction
  // one motion sample; the model freezes both axes once a sum leaves 12 bits
  task automatic move(input logic [7:0] x, input logic [7:0] y);
    int nx, ny;
    @(posedge sys_clk_in);
    dv <= 1'b1;
    xd <= x;
    yd <= y;
    @(posedge sys_clk_in);
    dv <= 1'b0;
    xd <= ~x;
    yd <= ~y;
    nx = xacc + int'($signed(x));
    ny = yacc + int'($signed(y));
    if (!m_ovf && (nx > 2047 || nx < -2048 || ny > 2047 || ny < -2048))
      m_ovf = 1'b1;
    else if (!m_ovf) begin
      xacc = nx;
      yacc = ny;
      m_pend |= (x != 8'h00 || y != 8'h00);
    end
  endtask
  // status then the three displacement bytes, then a second x low read
  task automatic read_all;
    @(negedge sys_clk_in);
    cmp({6'h00, mp, ov}, {6'h00, m_pend, m_ovf}, "flag pins");
    u_mxd_ctrl_model.burst(`MXD_REG_STATUS, 4, d, got);
    cmp(8'(got), 8'h04, "answers");
    cmp(d[0], exp_status(), "status");
    cmp(d[1], xacc[7:0], "x low");
    cmp(d[2], yacc[7:0], "y low");
    cmp(d[3], exp_hi(), "xy high");
    cmp(xyh, 8'h00, "high after read");
    cmp(yl, 8'h00, "y low after read");
    xacc = 0;
    yacc = 0;
    m_pend = 1'b0;
    m_ovf = 1'b0;
    u_mxd_ctrl_model.burst(`MXD_REG_X_LOW, 1, d, got);
    cmp(d[0], 8'h00, "x low reread");
  endtask
  // watchdog
  initial begin
    #1000000;
    n_errors++;
    summarize;
  end
  initial begin
    {rst_in, ce_in, lp} = 3'b111;
    {dv, sf, pur, m_pend, m_ovf} = 5'b00000;
    {xd, yd} = 16'h0000;
    {n_errors, checks, xacc, yacc} = '0;
    r = $urandom(30910);
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    u_mxd_ctrl_model.burst(`MXD_REG_STATUS, 2, d, got);
    cmp(d[0], `MXD_STATUS_RESET, "reset status");
    cmp(d[1], 8'h00, "reset x low");
    // rounds 0 and 1 run x up to +2032 and down to -2048, then overflow and freeze
    for (r = 0; r < 8; r++) begin
      @(posedge sys_clk_in);
      lp <= 1'($urandom);
      sf <= 1'($urandom);
      pur <= (r == 3);
      k = (r < 2) ? 20 : $urandom_range(1, 12);
      for (i = 0; i < k; i++)
        move(r == 0 ? 8'h7f : r == 1 ? 8'h80 : 8'($urandom), r < 2 ? 8'h01 : 8'($urandom));
      if (r == 5) begin
        u_mxd_ctrl_model.write(`MXD_REG_STATUS, 8'($urandom));
        {xacc, yacc, m_pend, m_ovf} = '0;
      end
      read_all;
    end
    // strobes are ignored while the clock enable is low
    @(posedge sys_clk_in);
    ce_in <= 1'b0;
    u_mxd_ctrl_model.burst(`MXD_REG_STATUS, 1, d, got);
    cmp(8'(got), 8'h00, "answer with enable low");
    @(posedge sys_clk_in);
    ce_in <= 1'b1;
    u_mxd_ctrl_model.burst(8'h10, 1, d, got);
    cmp(d[0], 8'h00, "unmapped read");
    summarize;
  end
endmodule
